// ===== logic/smta_defines.vh
`ifndef SMTA_DEFINES_VH
`define SMTA_DEFINES_VH

// bus addresses and command bytes
`define SMTA_SLAVE_ADDR     7'h4c
`define SMTA_ARA_BYTE       8'h19
`define SMTA_GCALL_BYTE     8'h00
`define SMTA_GCALL_RESET    8'h06
`define SMTA_HS_CODE        5'h01

// read pointers
`define SMTA_RD_LOCAL       8'h00
`define SMTA_RD_REMOTE      8'h01
`define SMTA_RD_STATUS      8'h02
`define SMTA_RD_CONFIG      8'h03
`define SMTA_RD_RATE        8'h04
`define SMTA_RD_LHI         8'h05
`define SMTA_RD_LLO         8'h06
`define SMTA_RD_RHI         8'h07
`define SMTA_RD_RLO         8'h08
`define SMTA_RD_RTHLIM      8'h19
`define SMTA_RD_LTHLIM      8'h20
`define SMTA_RD_HYST        8'h21
`define SMTA_RD_CONSEC      8'h22

// write pointers
`define SMTA_WR_CONFIG      8'h09
`define SMTA_WR_RATE        8'h0a
`define SMTA_WR_LHI         8'h0b
`define SMTA_WR_LLO         8'h0c
`define SMTA_WR_RHI         8'h0d
`define SMTA_WR_RLO         8'h0e
`define SMTA_WR_ONE_SHOT    8'h0f
`define SMTA_WR_RTHLIM      8'h19
`define SMTA_WR_LTHLIM      8'h20
`define SMTA_WR_HYST        8'h21
`define SMTA_WR_CONSEC      8'h22

// configuration fields
`define SMTA_CFG_MASK_BIT   7
`define SMTA_CFG_SLEEP_BIT  6
`define SMTA_CFG_SEL_BIT    5

// reset values
`define SMTA_RST_CONFIG     8'h00
`define SMTA_RST_RATE       8'h08
`define SMTA_RST_HI         8'h55
`define SMTA_RST_LO         8'h00
`define SMTA_RST_THLIM      8'h55
`define SMTA_RST_HYST       8'h0a
`define SMTA_RST_CONSEC     8'h81

// deglitch lengths in ref_clk samples
`define SMTA_FILT_FS        3'd2
`define SMTA_FILT_HS        3'd1

`endif

// ===== logic/smta_slave.v
`timescale 1ns/100ps
`include "smta_defines.vh"

////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser plus agreement filter for one bus line
module smta_deglitch (
  // clock and reset
  input  wire       ref_clk,
  input  wire       reset,
  // line
  input  wire       raw_in,
  input  wire [2:0] filt_len,
  output reg        clean_q
);
  reg       s1_q;
  reg       s2_q;
  reg [2:0] cnt_q;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      cnt_q   <= 3'h0;
      clean_q <= 1'b1;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      if (s2_q == clean_q) begin
        cnt_q <= 3'h0;
      end else if (cnt_q + 3'h1 >= filt_len) begin
        cnt_q   <= 3'h0;
        clean_q <= s2_q;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Operation
// - alert response byte while warning active: ack, send own address
// - returned address lsb is one for high violation, zero for low
// - arbitrate address bits; winner releases warning, loser keeps it
// - over-range low when either temperature passes its limit; unmaskable
// - over-range releases below limit minus hysteresis, default ten
// - configuration bit 5 picks pin 6 function; zero means early warning
// - second over-range mode uses ordinary high and low limits, hysteresis
// - early warning asserts after one to four consecutive violations
// - open remote diode also asserts early warning unless masked
// - configuration bit 7 set holds early warning inactive
// - warning clears on alert response only if cause ended, status cleared
// - diode fault keeps old remote result, sets status bit 2
// - master code not acknowledged; filters go high speed until stop
// - sleep finishes current conversion then idles; else converts
// - in sleep, write to pointer 0fh runs one conversion, data discarded
// - general call acked; second byte 06h resets all, aborts, releases
// - device answers seven-bit address 4ch plus direction bit
// - acknowledge on ninth clock; bytes eight bits msb first then ack
// - sda changes only while scl low; high-time change is start/stop
// - reads return register at last written pointer, which is retained
module smta_slave (
  // clock and reset
  input  wire       ref_clk,
  input  wire       reset,
  // bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  output reg        high_speed_bus_mode,
  // alarm pins, open drain
  output wire       overrange_out_n,
  output wire       overrange_oe,
  output wire       pin6_alarm_out_n,
  output wire       pin6_alarm_oe,
  // conversion engine
  input  wire [7:0] local_temp,
  input  wire [7:0] remote_temp,
  input  wire       diode_open,
  input  wire       conv_done,
  output reg        conv_start,
  output reg        conv_abort,
  output reg        conv_busy,
  output wire       sleep_request
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_WBYT = 7'h08;
  localparam [6:0] ST_WACK = 7'h10;
  localparam [6:0] ST_RBYT = 7'h20;
  localparam [6:0] ST_RACK = 7'h40;

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning and bus events
  wire       scl_f;
  wire       sda_f;
  reg        scl_p_q;
  reg        sda_p_q;
  wire [2:0] filt_len = high_speed_bus_mode ? `SMTA_FILT_HS : `SMTA_FILT_FS;

  smta_deglitch u_scl (.ref_clk(ref_clk), .reset(reset), .raw_in(scl_in),
                       .filt_len(filt_len), .clean_q(scl_f));
  smta_deglitch u_sda (.ref_clk(ref_clk), .reset(reset), .raw_in(sda_in),
                       .filt_len(filt_len), .clean_q(sda_f));

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_p_q;
  wire scl_fall = ~scl_f & scl_p_q;
  wire bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
  wire bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  reg  [6:0] state_q;
  reg  [3:0] bit_cnt_q;
  reg  [7:0] rx_sh_q;
  reg  [7:0] tx_sh_q;
  reg        first_byte_q;
  reg        gcall_q;
  reg        ara_q;
  reg        ara_won_q;
  reg        host_ack_q;
  reg  [7:0] pointer_q;
  reg  [7:0] config_q;
  reg  [7:0] rate_q;
  reg  [7:0] lhi_q;
  reg  [7:0] llo_q;
  reg  [7:0] rhi_q;
  reg  [7:0] rlo_q;
  reg  [7:0] rthlim_q;
  reg  [7:0] lthlim_q;
  reg  [7:0] hyst_q;
  reg  [7:0] consec_q;
  reg  [7:0] local_q;
  reg  [7:0] remote_q;
  reg  [6:0] flags_q;
  reg        soft_rst_q;
  reg        oneshot_q;
  reg        fault_seen_q;
  reg        eval_q;
  reg        overrange_out_n_q;
  reg        second_overrange_out_n_q;
  reg        alert_q;
  reg        alert_high_q;
  reg  [2:0] viol_cnt_q;
  reg  [7:0] rd_data;

  wire mask_en = config_q[`SMTA_CFG_MASK_BIT];
  wire sel_th2 = config_q[`SMTA_CFG_SEL_BIT];
  assign sleep_request = config_q[`SMTA_CFG_SLEEP_BIT];

  // read mux, write-only and unlisted pointers read zero
  always @* begin
    case (pointer_q)
      `SMTA_RD_LOCAL:  rd_data = local_q;
      `SMTA_RD_REMOTE: rd_data = remote_q;
      `SMTA_RD_STATUS: rd_data = {conv_busy, flags_q};
      `SMTA_RD_CONFIG: rd_data = config_q;
      `SMTA_RD_RATE:   rd_data = rate_q;
      `SMTA_RD_LHI:    rd_data = lhi_q;
      `SMTA_RD_LLO:    rd_data = llo_q;
      `SMTA_RD_RHI:    rd_data = rhi_q;
      `SMTA_RD_RLO:    rd_data = rlo_q;
      `SMTA_RD_RTHLIM: rd_data = rthlim_q;
      `SMTA_RD_LTHLIM: rd_data = lthlim_q;
      `SMTA_RD_HYST:   rd_data = hyst_q;
      `SMTA_RD_CONSEC: rd_data = consec_q;
      default:         rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave state machine
  wire       byte_done  = (bit_cnt_q == 4'h8);
  wire       addr_match = (rx_sh_q[7:1] == `SMTA_SLAVE_ADDR);
  wire       ara_hit    = (rx_sh_q == `SMTA_ARA_BYTE) & alert_q & ~sel_th2;
  wire       gc_hit     = (rx_sh_q == `SMTA_GCALL_BYTE);
  wire       hs_hit     = (rx_sh_q[7:3] == `SMTA_HS_CODE);
  wire       wr_strobe  = (state_q == ST_WBYT) & scl_fall & byte_done;
  wire       status_rd  = (state_q == ST_AACK) & scl_fall & rx_sh_q[0] &
                          ~ara_q & (pointer_q == `SMTA_RD_STATUS);
  wire [7:0] ara_byte   = {`SMTA_SLAVE_ADDR, alert_high_q};

  assign sda_out = 1'b0;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q             <= ST_IDLE;
      bit_cnt_q           <= 4'h0;
      rx_sh_q             <= 8'h00;
      tx_sh_q             <= 8'hff;
      first_byte_q        <= 1'b0;
      gcall_q             <= 1'b0;
      ara_q               <= 1'b0;
      ara_won_q           <= 1'b0;
      host_ack_q          <= 1'b0;
      sda_oe              <= 1'b0;
      high_speed_bus_mode <= 1'b0;
    end else begin
      ara_won_q <= 1'b0;
      if (bus_stop) begin
        state_q             <= ST_IDLE;
        sda_oe              <= 1'b0;
        high_speed_bus_mode <= 1'b0;
      end else if (bus_start) begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe    <= 1'b0;
        ara_q     <= 1'b0;
        gcall_q   <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          ST_ADDR, ST_WBYT: begin
            rx_sh_q   <= {rx_sh_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          ST_RBYT: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            // released a one but the line is low: another responder wins
            if (ara_q && tx_sh_q[7] && !sda_f) begin
              state_q <= ST_IDLE;
            end
          end
          ST_RACK:  host_ack_q <= ~sda_f;
          default:  state_q <= state_q;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (byte_done) begin
              if (hs_hit) begin
                high_speed_bus_mode <= 1'b1;
                state_q             <= ST_IDLE;
              end else if (addr_match || ara_hit || gc_hit) begin
                ara_q   <= ara_hit & ~addr_match;
                gcall_q <= gc_hit;
                sda_oe  <= 1'b1;
                state_q <= ST_AACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt_q    <= 4'h0;
            first_byte_q <= 1'b1;
            if (rx_sh_q[0]) begin
              tx_sh_q <= ara_q ? ara_byte : rd_data;
              sda_oe  <= ara_q ? ~ara_byte[7] : ~rd_data[7];
              state_q <= ST_RBYT;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= ST_WBYT;
            end
          end
          ST_WBYT: begin
            if (byte_done) begin
              sda_oe  <= 1'b1;
              state_q <= ST_WACK;
            end
          end
          ST_WACK: begin
            sda_oe       <= 1'b0;
            bit_cnt_q    <= 4'h0;
            first_byte_q <= 1'b0;
            state_q      <= ST_WBYT;
          end
          ST_RBYT: begin
            if (byte_done) begin
              sda_oe  <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b1};
              sda_oe  <= ~tx_sh_q[6];
            end
          end
          ST_RACK: begin
            bit_cnt_q <= 4'h0;
            if (ara_q) begin
              ara_won_q <= 1'b1;
              state_q   <= ST_IDLE;
            end else if (host_ack_q) begin
              tx_sh_q <= rd_data;
              sda_oe  <= ~rd_data[7];
              state_q <= ST_RBYT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file, general-call reset and one-shot
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pointer_q  <= 8'h00;
      config_q   <= `SMTA_RST_CONFIG;
      rate_q     <= `SMTA_RST_RATE;
      lhi_q      <= `SMTA_RST_HI;
      llo_q      <= `SMTA_RST_LO;
      rhi_q      <= `SMTA_RST_HI;
      rlo_q      <= `SMTA_RST_LO;
      rthlim_q   <= `SMTA_RST_THLIM;
      lthlim_q   <= `SMTA_RST_THLIM;
      hyst_q     <= `SMTA_RST_HYST;
      consec_q   <= `SMTA_RST_CONSEC;
      soft_rst_q <= 1'b0;
      oneshot_q  <= 1'b0;
    end else begin
      soft_rst_q <= 1'b0;
      oneshot_q  <= 1'b0;
      if (soft_rst_q) begin
        pointer_q <= 8'h00;
        config_q  <= `SMTA_RST_CONFIG;
        rate_q    <= `SMTA_RST_RATE;
        lhi_q     <= `SMTA_RST_HI;
        llo_q     <= `SMTA_RST_LO;
        rhi_q     <= `SMTA_RST_HI;
        rlo_q     <= `SMTA_RST_LO;
        rthlim_q  <= `SMTA_RST_THLIM;
        lthlim_q  <= `SMTA_RST_THLIM;
        hyst_q    <= `SMTA_RST_HYST;
        consec_q  <= `SMTA_RST_CONSEC;
      end else if (wr_strobe && gcall_q) begin
        // other second bytes are acknowledged and dropped
        soft_rst_q <= first_byte_q & (rx_sh_q == `SMTA_GCALL_RESET);
      end else if (wr_strobe && first_byte_q) begin
        pointer_q <= rx_sh_q;
      end else if (wr_strobe) begin
        case (pointer_q)
          `SMTA_WR_CONFIG:   config_q  <= rx_sh_q;
          `SMTA_WR_RATE:     rate_q    <= rx_sh_q;
          `SMTA_WR_LHI:      lhi_q     <= rx_sh_q;
          `SMTA_WR_LLO:      llo_q     <= rx_sh_q;
          `SMTA_WR_RHI:      rhi_q     <= rx_sh_q;
          `SMTA_WR_RLO:      rlo_q     <= rx_sh_q;
          `SMTA_WR_ONE_SHOT: oneshot_q <= 1'b1;
          `SMTA_WR_RTHLIM:   rthlim_q  <= rx_sh_q;
          `SMTA_WR_LTHLIM:   lthlim_q  <= rx_sh_q;
          `SMTA_WR_HYST:     hyst_q    <= rx_sh_q;
          `SMTA_WR_CONSEC:   consec_q  <= rx_sh_q;
          default:           rate_q    <= rate_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing and result capture
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_start   <= 1'b0;
      conv_abort   <= 1'b0;
      conv_busy    <= 1'b0;
      fault_seen_q <= 1'b0;
      local_q      <= 8'h00;
      remote_q     <= 8'h00;
      eval_q       <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      eval_q     <= 1'b0;
      if (soft_rst_q) begin
        conv_abort   <= conv_busy;
        conv_busy    <= 1'b0;
        fault_seen_q <= 1'b0;
        local_q      <= 8'h00;
        remote_q     <= 8'h00;
      end else if (conv_busy) begin
        fault_seen_q <= fault_seen_q | diode_open;
        if (conv_done) begin
          conv_busy <= 1'b0;
          eval_q    <= 1'b1;
          local_q   <= local_temp;
          if (!(fault_seen_q || diode_open)) begin
            remote_q <= remote_temp;
          end
        end
      end else if (!sleep_request || oneshot_q) begin
        // sleep only stops the next start, never cuts one short
        conv_start   <= 1'b1;
        conv_busy    <= 1'b1;
        fault_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit comparison, status flags and alarm pins
  wire       lhi_v  = local_q >= lhi_q;
  wire       llo_v  = local_q < llo_q;
  wire       rhi_v  = remote_q >= rhi_q;
  wire       rlo_v  = remote_q < rlo_q;
  wire       lth_v  = local_q >= lthlim_q;
  wire       rth_v  = remote_q >= rthlim_q;
  wire [8:0] l_up   = {1'b0, local_q} + {1'b0, hyst_q};
  wire [8:0] r_up   = {1'b0, remote_q} + {1'b0, hyst_q};
  wire [8:0] llo_up = {1'b0, llo_q} + {1'b0, hyst_q};
  wire [8:0] rlo_up = {1'b0, rlo_q} + {1'b0, hyst_q};
  wire       th_clr = (l_up < {1'b0, lthlim_q}) &
                      (r_up < {1'b0, rthlim_q});
  wire       t2_clr = (l_up < {1'b0, lhi_q}) & (r_up < {1'b0, rhi_q}) &
                      ({1'b0, local_q} >= llo_up) &
                      ({1'b0, remote_q} >= rlo_up);
  wire       viol   = lhi_v | llo_v | rhi_v | rlo_v;
  wire [2:0] need   = consec_q[3] ? 3'd4 : consec_q[2] ? 3'd3 :
                      consec_q[1] ? 3'd2 : 3'd1;
  wire [6:0] new_f  = {lhi_v, llo_v, rhi_v, rlo_v, fault_seen_q,
                       rth_v, lth_v};
  wire       cause_gone = ~viol & ~fault_seen_q & (flags_q == 7'h00);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags_q      <= 7'h00;
      overrange_out_n_q      <= 1'b0;
      second_overrange_out_n_q     <= 1'b0;
      alert_q      <= 1'b0;
      alert_high_q <= 1'b0;
      viol_cnt_q   <= 3'd0;
    end else if (soft_rst_q) begin
      flags_q    <= 7'h00;
      overrange_out_n_q    <= 1'b0;
      second_overrange_out_n_q   <= 1'b0;
      alert_q    <= 1'b0;
      viol_cnt_q <= 3'd0;
    end else begin
      // a fresh result landing on a status read still sets its flag
      flags_q <= (status_rd ? 7'h00 : flags_q) | (eval_q ? new_f : 7'h00);
      if (eval_q) begin
        if (lth_v || rth_v) begin
          overrange_out_n_q <= 1'b1;
        end else if (th_clr) begin
          overrange_out_n_q <= 1'b0;
        end
        if (viol) begin
          second_overrange_out_n_q <= 1'b1;
        end else if (t2_clr) begin
          second_overrange_out_n_q <= 1'b0;
        end
        viol_cnt_q <= viol ? ((viol_cnt_q < need) ? viol_cnt_q + 3'd1
                                                  : viol_cnt_q)
                           : 3'd0;
        if ((viol && viol_cnt_q + 3'd1 >= need) || fault_seen_q) begin
          alert_q      <= 1'b1;
          alert_high_q <= lhi_v | rhi_v;
        end else if (ara_won_q && cause_gone) begin
          // a result landing on the clear cycle must not swallow the clear
          alert_q <= 1'b0;
        end
      end else if (ara_won_q && cause_gone) begin
        alert_q <= 1'b0;
      end
    end
  end

  // pin 6 follows the selected function; mask only gates the warning
  wire pin6_drive = sel_th2 ? second_overrange_out_n_q : (alert_q & ~mask_en);

  assign overrange_oe     = overrange_out_n_q;
  assign overrange_out_n  = ~overrange_out_n_q;
  assign pin6_alarm_oe    = pin6_drive;
  assign pin6_alarm_out_n = ~pin6_drive;

endmodule

// ===== test/smta_host.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// bus host; scl stands high between frames, 8 ref_clk cycles per bit
module smta_host (
  // clock
  input  wire ref_clk,
  // bus
  input  wire sda_line,
  output reg  scl,
  output reg  sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task w(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // long first wait lets a slave ack drop before scl rises again
  task start;
    sda_low <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(3);
    sda_low <= 1'b1;
    w(3);
    scl <= 1'b0;
    w(2);
  endtask
  task stop;
    sda_low <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(3);
    sda_low <= 1'b0;
    w(6);
  endtask
  // eight bits msb first then the ack slot; a one releases the line
  // six low cycles: the slave moves sda five cycles after scl falls
  task b9(input [8:0] v, output [8:0] got);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      sda_low <= ~v[i];
      w(4);
      scl <= 1'b1;
      w(2);
      got[i] = sda_line;
      scl <= 1'b0;
      w(2);
    end
  endtask
endmodule

// ===== test/smta_slave_sva.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module smta_slave_sva (
  // clock and reset
  input wire       ref_clk,
  input wire       reset,
  // bus
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_oe,
  input wire       high_speed_bus_mode,
  // alarms
  input wire       overrange_out_n,
  input wire       pin6_alarm_out_n,
  // converter
  input wire [7:0] local_temp,
  input wire       conv_done,
  input wire       conv_start,
  input wire       conv_abort,
  input wire       conv_busy,
  input wire       sleep_request
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // a drive change with scl high would read as start or stop
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed while scl high");
  a_hs_on_stop: assert property (scl_in && $rose(sda_in)
    && high_speed_bus_mode |-> ##[1:8] !high_speed_bus_mode)
    else $error("high speed mode kept after stop");
  a_start_pulse: assert property (
    conv_start |=> conv_busy && !conv_start)
    else $error("conversion start not a single pulse");
  // busy drops on the edge after done, the restart one edge later
  a_awake_again: assert property (
    conv_busy && conv_done && !sleep_request |-> ##2 conv_start)
    else $error("no restart while awake");
  a_sleep_idle: assert property (
    conv_busy && conv_done && sleep_request |=> !conv_busy)
    else $error("converter busy after sleep");
  a_busy_cause: assert property (
    $fell(conv_busy) |-> $past(conv_done) || conv_abort)
    else $error("busy dropped without cause");
  a_hot_overrange_out_n: assert property (conv_busy && conv_done
    && local_temp == 8'hff |-> ##[1:3] !overrange_out_n)
    else $error("overrange missing at full scale");
  a_reset_release: assert property (conv_abort |-> ##[0:2]
    (overrange_out_n && pin6_alarm_out_n))
    else $error("alarms held after soft reset");
  cover property (conv_abort);
  cover property (high_speed_bus_mode && sda_oe);
  cover property (!pin6_alarm_out_n && overrange_out_n);
endmodule

bind smta_slave smta_slave_sva u_sva (
  .ref_clk(ref_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .high_speed_bus_mode(high_speed_bus_mode),
  .overrange_out_n(overrange_out_n), .pin6_alarm_out_n(pin6_alarm_out_n),
  .local_temp(local_temp), .conv_done(conv_done), .conv_start(conv_start),
  .conv_abort(conv_abort), .conv_busy(conv_busy),
  .sleep_request(sleep_request));

// ===== test/test_smta_slave.sv
`timescale 1ns/100ps
`include "smta_defines.vh"

////////////////////////////////////////////////////////////////////////////
module test_smta_slave;
  localparam [7:0] adw = {`SMTA_SLAVE_ADDR, 1'b0};
  localparam [7:0] adr = {`SMTA_SLAVE_ADDR, 1'b1};
  reg        ref_clk     = 1'b0;
  reg        reset       = 1'b1;
  reg  [7:0] local_temp  = 8'h20;
  reg  [7:0] remote_temp = 8'h20;
  reg        diode_open  = 1'b0;
  reg        conv_done   = 1'b0;
  reg  [8:0] g;
  reg  [7:0] rb;
  integer    cnt = 0, starts = 0, n0 = 0, num_errors = 0, samples_checked = 0;
  wire       scl, host_low, sda_out, sda_oe, high_speed_bus_mode;
  wire       overrange_out_n, overrange_oe, pin6_alarm_out_n, pin6_alarm_oe;
  wire       conv_start, conv_abort, conv_busy, sleep_request;
  wire       sda_line = !(host_low || (sda_oe && !sda_out));
  always #50 ref_clk = ~ref_clk;
  // converter stand-in: result ready 20 cycles after each start
  always @(posedge ref_clk) begin
    conv_done <= (cnt == 1);
    cnt <= conv_start ? 20 : (cnt > 0 ? cnt - 1 : 0);
    if (conv_start) starts <= starts + 1;
  end
  smta_slave u_dut (.ref_clk(ref_clk), .reset(reset), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .high_speed_bus_mode(high_speed_bus_mode),
    .overrange_out_n(overrange_out_n), .overrange_oe(overrange_oe),
    .pin6_alarm_out_n(pin6_alarm_out_n), .pin6_alarm_oe(pin6_alarm_oe),
    .local_temp(local_temp), .remote_temp(remote_temp),
    .diode_open(diode_open), .conv_done(conv_done), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_busy(conv_busy),
    .sleep_request(sleep_request));
  smta_host u_h (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
    .sda_low(host_low));
  task chk(input string n, input [7:0] e, input [7:0] a);
    samples_checked = samples_checked + 1;
    if (a !== e) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", n, e, a);
    end
  endtask
  task tx(input [7:0] b, input [7:0] ea);
    u_h.b9({b, 1'b1}, g);
    chk("ack", ea, {7'h00, g[0]});
  endtask
  task fin;
    u_h.b9(9'h1ff, g);
    u_h.stop;
    rb = g[8:1];
  endtask
  task wr(input [7:0] p, input [7:0] d);
    u_h.start;
    tx(adw, 8'h00);
    tx(p, 8'h00);
    tx(d, 8'h00);
    u_h.stop;
  endtask
  task rd(input [7:0] p);
    u_h.start;
    tx(adw, 8'h00);
    tx(p, 8'h00);
    u_h.start;
    tx(adr, 8'h00);
    fin;
  endtask
  task ara;
    u_h.start;
    u_h.b9({`SMTA_ARA_BYTE, 1'b1}, g);
    fin;
  endtask
  task convn(input integer n);
    repeat (n) @(posedge conv_done);
    repeat (3) @(posedge ref_clk);
  endtask
  task pins(input e_ovr, input e_p6);
    chk("overrange", {7'h00, e_ovr}, {7'h00, overrange_out_n});
    chk("pin6", {7'h00, e_p6}, {7'h00, pin6_alarm_out_n});
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run needs about 7000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    pins(1'b1, 1'b1);
    u_h.start;
    tx(adw ^ 8'h02, 8'h01);
    u_h.stop;
    $display("test reset_and_address done");
    local_temp <= 8'h55;
    convn(2);
    pins(1'b0, 1'b0);
    local_temp <= 8'h4b;
    convn(2);
    pins(1'b0, 1'b0);
    local_temp <= 8'h4a;
    convn(2);
    pins(1'b1, 1'b0);
    ara;
    chk("alert reply", adr, rb);
    pins(1'b1, 1'b0);
    rd(`SMTA_RD_STATUS);
    chk("status", 8'h41, rb & 8'h7f);
    ara;
    chk("alert reply", adr, rb);
    pins(1'b1, 1'b1);
    $display("test overrange_and_alert done");
    wr(`SMTA_WR_CONFIG, 8'h80);
    local_temp <= 8'h56;
    convn(2);
    pins(1'b0, 1'b1);
    wr(`SMTA_WR_CONFIG, 8'h20);
    convn(1);
    pins(1'b0, 1'b0);
    local_temp <= 8'h4a;
    convn(2);
    pins(1'b1, 1'b1);
    $display("test pin6_modes done");
    wr(`SMTA_WR_CONSEC, 8'h0e);
    wr(`SMTA_WR_CONFIG, 8'h00);
    rd(`SMTA_RD_STATUS);
    ara;
    local_temp <= 8'hff;
    convn(3);
    pins(1'b0, 1'b1);
    convn(1);
    pins(1'b0, 1'b0);
    $display("test consecutive done");
    local_temp <= 8'h20;
    u_h.start;
    tx(`SMTA_GCALL_BYTE, 8'h00);
    tx(`SMTA_GCALL_RESET, 8'h00);
    u_h.stop;
    pins(1'b1, 1'b1);
    rd(`SMTA_RD_CONSEC);
    chk("consecutive", `SMTA_RST_CONSEC, rb);
    remote_temp <= 8'h30;
    diode_open <= 1'b1;
    convn(1);
    pins(1'b1, 1'b0);
    rd(`SMTA_RD_STATUS);
    chk("open flag", 8'h04, rb & 8'h04);
    rd(`SMTA_RD_REMOTE);
    chk("remote", 8'h20, rb);
    diode_open <= 1'b0;
    $display("test reset_and_fault done");
    u_h.start;
    tx(8'h08, 8'h01);
    chk("high speed", 8'h01, {7'h00, high_speed_bus_mode});
    u_h.start;
    tx(adw, 8'h00);
    u_h.stop;
    chk("high speed", 8'h00, {7'h00, high_speed_bus_mode});
    $display("test high_speed done");
    wr(`SMTA_WR_CONFIG, 8'h40);
    chk("sleep", 8'h01, {7'h00, sleep_request});
    repeat (2000) @(posedge ref_clk);
    chk("busy", 8'h00, {7'h00, conv_busy});
    n0 = starts;
    wr(`SMTA_WR_ONE_SHOT, 8'h5a);
    repeat (100) @(posedge ref_clk);
    chk("one shot", 8'h01, starts[7:0] - n0[7:0]);
    chk("busy", 8'h00, {7'h00, conv_busy});
    rd(`SMTA_RD_CONFIG);
    chk("config", 8'h40, rb);
    $display("test sleep done");
    conclude;
  end
endmodule
